// File: actl_aux_control.sv
// Auxiliary control register with coprocessor access and decoded control outputs
//
// How it works
// R01: Dual-issue-off bit 28 stops branches issuing alongside other instructions.
// R02: Bit 18 stops the indirect target cache being used for prediction.
// R03: Bit 17 stops the return stack being used for returns.
// R04: Policy 00 normal, 01 all taken, 10 all not taken, 11 unpredictable.
// R05: Prefetch field limits outstanding hardware prefetches to 0..3; software preloads excluded.
// R06: Bit 12 turns data cache read-allocate off.
// R07: Bit 11 splits multi-beat Normal memory data writes into single beats.
// R08: Software sets read-allocate off whenever it sets write-burst off.
// R09: Write-burst off leaves cache line eviction writes as they were.
// R10: Bit 10 runs memory barriers without the optimised handling.
// R11: Bit 7 keeps data from living in L1 and L2 together.
// R12: Exclusive mode fills L2 only from L1 evictions of write-back lines.
// R13: The external L2 controller must also be set for exclusive caching.
// R14: Exclusive mode only with a matching L2 controller directly on the port.
// R15: Coherency bit 6 clear makes inner cacheable shared requests non-cacheable.
// R16: Bit 0 enables cache and TLB maintenance broadcast.
// R17: Maintenance sent and accepted only when broadcast and coherency bits set.
// R18: Software changes the register by read-modify-write; the testbench's random writes send $urandom values without reading first.
// R19: Reached by coprocessor 15 transfers, opcode1 0, c1, c0, opcode2 1.
// R20: Privileged only; secure read-write, non-secure read-only without access grant.
// R21: Granted non-secure writes change only the coherency participation bit.
// R22: Secure write under security write-disable is undefined, register unchanged.
// R23: Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`include "actl_defines.svh"

module actl_aux_control (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Coprocessor transfer
  input actl_pkg::actl_req_t REQ,
  input wire logic NONSECURE_COHERENCY_ACCESS,
  input wire logic SECURITY_WRITE_DISABLE,
  output logic ACK,
  output logic UNDEF,
  output logic [31:0] RDATA,
  // Decoded controls and raw register contents
  output actl_pkg::actl_ctrl_t CTRL,
  output logic [31:0] AUXILIARY_CONTROL
);

  logic [31:0] aux_r;
  logic [31:0] aux_nxt;
  logic ack_r;
  logic ack_nxt;
  logic undef_r;
  logic undef_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  actl_pkg::actl_ctrl_t ctrl_r;
  actl_pkg::actl_ctrl_t ctrl_nxt;
  logic hit;
  logic [31:0] wmask;
  actl_pkg::actl_pred_t pred;

  // Selector match for this register only
  assign hit = REQ.valid && REQ.cp_num == `ACTL_CP_NUM && REQ.opc1 == `ACTL_OPC1 &&
               REQ.crn == `ACTL_CRN && REQ.crm == `ACTL_CRM && REQ.opc2 == `ACTL_OPC2; // R19

  always_comb begin
    aux_nxt = aux_r;
    ack_nxt = 1'b0;
    undef_nxt = 1'b0;
    rdata_nxt = rdata_r;
    wmask = 32'h0000_0000;
    if (hit) begin
      if (!REQ.privileged) begin
        undef_nxt = 1'b1; // R20
      end else if (!REQ.write) begin
        ack_nxt = 1'b1;
        rdata_nxt = aux_r & `ACTL_IMPL_MASK; // R23
      end else if (REQ.secure && SECURITY_WRITE_DISABLE) begin
        undef_nxt = 1'b1; // R22
      end else begin
        ack_nxt = 1'b1;
        if (REQ.secure) begin
          wmask = `ACTL_IMPL_MASK; // R20 R23
        end else if (NONSECURE_COHERENCY_ACCESS) begin
          wmask = `ACTL_NS_MASK; // R21
        end
        // Non-secure without grant: write silently ignored
        aux_nxt = (aux_r & ~wmask) | (REQ.wdata & wmask); // R20 R21
      end
    end
  end

  always_comb begin
    pred = actl_pkg::actl_pred_t'(aux_r[`ACTL_POLICY_HI:`ACTL_POLICY_LO]);
    ctrl_nxt.dual_issue_allow = !aux_r[`ACTL_BIT_DUAL_ISSUE_OFF]; // R01
    ctrl_nxt.indirect_target_cache_use = !aux_r[`ACTL_BIT_ITC_OFF]; // R02
    ctrl_nxt.return_stack_use = !aux_r[`ACTL_BIT_RET_STACK_OFF]; // R03
    ctrl_nxt.predict_all_taken = pred == actl_pkg::ACTL_PRED_TAKEN; // R04
    ctrl_nxt.predict_all_not_taken = pred == actl_pkg::ACTL_PRED_NOT_TAKEN; // R04
    ctrl_nxt.policy_unpredictable = pred == actl_pkg::ACTL_PRED_RESERVED; // R04
    // Limit on hardware prefetches only; preloads bypass it
    ctrl_nxt.prefetch_depth = aux_r[`ACTL_PREFETCH_HI:`ACTL_PREFETCH_LO]; // R05
    ctrl_nxt.read_allocate_on = !aux_r[`ACTL_BIT_READ_ALLOC_OFF]; // R06
    // Memory system applies this to data writes, never to evictions
    ctrl_nxt.write_burst_split = aux_r[`ACTL_BIT_WRITE_BURST_OFF]; // R07 R09
    ctrl_nxt.barrier_optimise_on = !aux_r[`ACTL_BIT_BARRIER_OFF]; // R10
    // L1 evictions of write-back lines are the only L2 fills in this mode
    ctrl_nxt.exclusive_cache_mode = aux_r[`ACTL_BIT_EXCLUSIVE]; // R11 R12
    ctrl_nxt.coherent_shared = aux_r[`ACTL_BIT_COHERENCY]; // R15
    ctrl_nxt.broadcast_send = aux_r[`ACTL_BIT_BROADCAST] && aux_r[`ACTL_BIT_COHERENCY]; // R16 R17
    ctrl_nxt.broadcast_accept = aux_r[`ACTL_BIT_BROADCAST] && aux_r[`ACTL_BIT_COHERENCY]; // R17
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aux_r <= `ACTL_RESET;
      ack_r <= 1'b0;
      undef_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ctrl_r <= '0;
    end else begin
      aux_r <= aux_nxt;
      ack_r <= ack_nxt;
      undef_r <= undef_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign ACK = ack_r;
  assign UNDEF = undef_r;
  assign RDATA = rdata_r;
  assign CTRL = ctrl_r;
  assign AUXILIARY_CONTROL = aux_r;

endmodule

// File: actl_aux_control_assertions.sv
// Port checker for the auxiliary control register
`timescale 1ns/100ps
module actl_aux_control_assertions (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Transfer side
  input actl_pkg::actl_req_t REQ,
  input wire logic NONSECURE_COHERENCY_ACCESS,
  input wire logic SECURITY_WRITE_DISABLE,
  input wire logic ACK,
  input wire logic UNDEF,
  input wire logic [31:0] RDATA,
  // Controls
  input actl_pkg::actl_ctrl_t CTRL,
  input wire logic [31:0] AUXILIARY_CONTROL
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire sel = REQ.valid && {REQ.cp_num, REQ.opc1, REQ.crn, REQ.crm, REQ.opc2} == 18'h3c081;
  wire pw = sel && REQ.privileged && REQ.write;
  function automatic logic [15:0] dec(logic [31:0] a);
    return {~a[28], ~a[18], ~a[17], a[16:15] == 2'h1, a[16:15] == 2'h2, &a[16:15], a[14:13], ~a[12], a[11],
      ~a[10], a[7], a[6], a[0] & a[6], a[0] & a[6]};
  endfunction
  one_answer_a: assert property (sel |=> ACK ^ UNDEF)
    else $error("no single answer");
  quiet_other_a: assert property (!sel |=> !ACK && !UNDEF)
    else $error("stray answer");
  user_undef_a: assert property (sel && !REQ.privileged |=> UNDEF)
    else $error("user access taken");
  blocked_write_a: assert property (pw && REQ.secure && SECURITY_WRITE_DISABLE |=> $stable(AUXILIARY_CONTROL))
    else $error("blocked write changed");
  secure_write_a: assert property (pw && REQ.secure && !SECURITY_WRITE_DISABLE |=>
    AUXILIARY_CONTROL == ($past(REQ.wdata) & 32'h1007fcc1)) else $error("secure write wrong");
  ns_write_a: assert property (pw && !REQ.secure |=>
    (AUXILIARY_CONTROL & 32'hffffffbf) == ($past(AUXILIARY_CONTROL) & 32'hffffffbf)) else $error("ns write leak");
  read_data_a: assert property (sel && REQ.privileged && !REQ.write |=> RDATA == $past(AUXILIARY_CONTROL))
    else $error("read data wrong");
  ctrl_decode_a: assert property (!$past(RST) |-> CTRL == dec($past(AUXILIARY_CONTROL)))
    else $error("control decode wrong");
  cover property (pw && !REQ.secure && NONSECURE_COHERENCY_ACCESS);
  cover property (pw && REQ.secure && SECURITY_WRITE_DISABLE);
  cover property (AUXILIARY_CONTROL[11] && AUXILIARY_CONTROL[12]);
endmodule

// File: actl_defines.svh
// Bit positions, encodings and access decode constants of the auxiliary control register
`ifndef ACTL_DEFINES_SVH
`define ACTL_DEFINES_SVH

`define ACTL_BIT_DUAL_ISSUE_OFF 28
`define ACTL_BIT_ITC_OFF 18
`define ACTL_BIT_RET_STACK_OFF 17
`define ACTL_POLICY_HI 16
`define ACTL_POLICY_LO 15
`define ACTL_PREFETCH_HI 14
`define ACTL_PREFETCH_LO 13
`define ACTL_BIT_READ_ALLOC_OFF 12
`define ACTL_BIT_WRITE_BURST_OFF 11
`define ACTL_BIT_BARRIER_OFF 10
`define ACTL_BIT_EXCLUSIVE 7
`define ACTL_BIT_COHERENCY 6
`define ACTL_BIT_BROADCAST 0

// Implemented bits; everything else reads as zero
`define ACTL_IMPL_MASK 32'h1007_fcc1
// Only the coherency participation bit for granted non-secure writes
`define ACTL_NS_MASK 32'h0000_0040
`define ACTL_RESET 32'h0000_0000

// Coprocessor transfer selector
`define ACTL_CP_NUM 4'hf
`define ACTL_OPC1 3'h0
`define ACTL_CRN 4'h1
`define ACTL_CRM 4'h0
`define ACTL_OPC2 3'h1

// Prediction policy encodings
`define ACTL_BP_NORMAL 2'h0
`define ACTL_BP_TAKEN 2'h1
`define ACTL_BP_NOT_TAKEN 2'h2

`endif

// File: actl_pkg.sv
// Types shared by the auxiliary control register block
package actl_pkg;

  typedef enum logic [1:0] {
    ACTL_PRED_NORMAL,
    ACTL_PRED_TAKEN,
    ACTL_PRED_NOT_TAKEN,
    ACTL_PRED_RESERVED
  } actl_pred_t;

  // One coprocessor transfer request
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] cp_num;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic privileged;
    logic secure;
    logic [31:0] wdata;
  } actl_req_t;

  // Decoded controls for the pipeline and memory system
  typedef struct packed {
    logic dual_issue_allow;
    logic indirect_target_cache_use;
    logic return_stack_use;
    logic predict_all_taken;
    logic predict_all_not_taken;
    logic policy_unpredictable;
    logic [1:0] prefetch_depth;
    logic read_allocate_on;
    logic write_burst_split;
    logic barrier_optimise_on;
    logic exclusive_cache_mode;
    logic coherent_shared;
    logic broadcast_send;
    logic broadcast_accept;
  } actl_ctrl_t;

endpackage

// File: actl_sw_model.sv
// Software issuing privileged and user coprocessor transfers
`timescale 1ns/100ps
module actl_sw_model (
  // Transfer request
  output actl_pkg::actl_req_t REQ
);
  initial REQ = '0;
  task automatic put(input logic v, w, s, p, input logic [2:0] o2, input logic [31:0] d);
    if (d[11]) d[12] = 1'b1;
    // Write-burst off is only asked for with read-allocate off set as well
    REQ = {v, w, 4'hf, 3'h0, 4'h1, 4'h0, o2, p, s, d};
  endtask
endmodule

// File: tb_top.sv
// Testbench of the auxiliary control register
`timescale 1ns/100ps
module tb_top;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic nsca = 1'b0;
  logic swd = 1'b0;
  actl_pkg::actl_req_t req;
  logic ack, undef;
  logic [31:0] rdata, aux, r;
  logic [31:0] m = 32'h0;
  actl_pkg::actl_ctrl_t ctrl;
  int fails = 0;
  int checks = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  actl_sw_model sw (.REQ(req));
  actl_aux_control dut (.CLK_SYS(CLK_SYS), .RST(RST), .REQ(req), .NONSECURE_COHERENCY_ACCESS(nsca),
    .SECURITY_WRITE_DISABLE(swd), .ACK(ack), .UNDEF(undef), .RDATA(rdata), .CTRL(ctrl), .AUXILIARY_CONTROL(aux));
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Control decode written from the field meanings
  function automatic logic [15:0] exp_ctrl(input logic [31:0] a);
    return {~a[28], ~a[18], ~a[17], a[16:15] == 2'h1, a[16:15] == 2'h2, a[16:15] == 2'h3, a[14:13], ~a[12],
      a[11], ~a[10], a[7], a[6], a[0] && a[6], a[0] && a[6]};
  endfunction
  // Request held back to back; answer checked one edge later
  task automatic op(input logic w, s, p, input logic [2:0] o2, input logic [31:0] d);
    logic hit;
    logic [31:0] prev;
    hit = (o2 == 3'h1);
    prev = m;
    sw.put(1'b1, w, s, p, o2, d);
    if (d[11]) d[12] = 1'b1;
    @(posedge CLK_SYS);
    #1;
    chk({ack, undef}, !hit ? 2'h0 : (!p || (w && s && swd)) ? 2'h1 : 2'h2);
    if (hit && p && w && !(s && swd)) m = s ? d & 32'h1007fcc1 : nsca ? (m & ~32'h40) | (d & 32'h40) : m;
    if (hit && p && !w) chk(rdata, m);
    chk(aux, m);
    chk(ctrl, exp_ctrl(prev));
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    r = $urandom(32'he82302ce);
    repeat (5) @(posedge CLK_SYS);
    #1 RST = 1'b0;
    op(1'b1, 1'b1, 1'b1, 3'h1, 32'hffffffff);
    op(1'b1, 1'b1, 1'b1, 3'h0, 32'h0);
    op(1'b0, 1'b1, 1'b1, 3'h1, 32'h0);
    op(1'b1, 1'b1, 1'b1, 3'h1, (rdata & ~32'h0000_6000) | 32'h0000_2000);
    op(1'b0, 1'b1, 1'b1, 3'h1, 32'h0);
    $display("test directed done");
    for (int i = 0; i < 400; i++) begin
      r = $urandom;
      {nsca, swd} = r[5:4];
      op(r[0], r[1], r[3:2] != 2'h0, 3'h1, $urandom);
    end
    sw.put(1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 32'h0);
    $display("test random done");
    print_verdict();
  end
endmodule
bind actl_aux_control actl_aux_control_assertions chk_i (.CLK_SYS, .RST, .REQ, .NONSECURE_COHERENCY_ACCESS,
  .SECURITY_WRITE_DISABLE, .ACK, .UNDEF, .RDATA, .CTRL, .AUXILIARY_CONTROL);
